// File: pwm_engine_pkg.sv
package pwm_engine_pkg;
  localparam int NUM_RAILS      = 4;
  localparam int NUM_STAGES     = 8;
  localparam int CNT_W          = 16;
  localparam int DUTY_W         = 16;
  localparam int CUR_W          = 12;
  localparam int ACC_W          = 20;
  localparam int SPREAD_NUM     = 3;
  localparam int SPREAD_DEN     = 13;
  localparam int CLK_MHZ        = 100;
  localparam int SAMPLE_US      = 200;
  localparam int SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;
  localparam int FILT_SHIFT     = 2;
  localparam int SYNC_OUT_LSB   = 8;
  localparam int SYNC_OUT_OFF   = 4;
  localparam logic [15:0] SYNC_CFG_RST = 16'hFF00;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h0064;

  typedef enum logic [1:0] {
    BANK_RAMP    = 2'b00,
    BANK_REGULAR = 2'b01,
    BANK_LIGHT   = 2'b10
  } coef_bank_t;

  typedef struct packed {
    logic [15:0] oc_limit;
    logic [15:0] uc_limit;
    logic [15:0] light_lo;
    logic [15:0] light_hi;
  } rail_limits_t;

  typedef struct packed {
    logic [11:0] gain;
    logic [11:0] offset;
  } stage_cal_t;
endpackage

// File: stage_pulse_engine.sv
`timescale 1ns/1ps
module stage_pulse_engine
  import pwm_engine_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Timing
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] start_val,
  input  wire logic [DUTY_W-1:0] duty,
  input  wire logic         restart,
  input  wire logic         enable,
  // Outputs
  output logic              pulse,
  output logic              wrap
);
  logic [W-1:0]          cnt_r;
  logic [W+DUTY_W-1:0]   prod;
  logic [W-1:0]          thresh;

  // Full-scale duty maps to one count less than the whole period
  assign prod   = period * duty;
  assign thresh = prod[W+DUTY_W-1:DUTY_W];

  always_ff @(posedge clk) begin
    // Reset loads the phase-shifted start so rail and stage spreads apply
    if (rst) begin
      cnt_r <= start_val;
    end else if (ce) begin
      if (restart) begin
        cnt_r <= start_val;
      end else if (cnt_r >= period - 1'b1) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign wrap  = ce && (cnt_r == '0);
  assign pulse = enable && (cnt_r < thresh);
endmodule

// File: current_monitor.sv
`timescale 1ns/1ps
module current_monitor
  import pwm_engine_pkg::*;
(
  // Clock
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Sample
  input  wire logic              load,
  input  wire logic [CUR_W-1:0]  raw,
  input  wire stage_cal_t        cal,
  // Result
  output logic [15:0]            avg
);
  logic [ACC_W-1:0] scaled;
  logic [ACC_W+1:0] acc_r;
  logic signed [ACC_W+2:0] delta;

  assign scaled = ACC_W'((24'(raw) * 24'(cal.gain)) >> 8) + ACC_W'(cal.offset);
  assign delta  = $signed({1'b0, ACC_W'(0), 2'b00}) +
                  $signed({3'b000, scaled}) - $signed({1'b0, acc_r[ACC_W+1:0]} >>> FILT_SHIFT);

  // First-order smoothing, time constant near 3.5 sample intervals
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= '0;
    end else if (ce && load) begin
      acc_r <= acc_r + (ACC_W+2)'(delta);
    end
  end
  assign avg = acc_r[FILT_SHIFT +: 16];
endmodule

// File: multirail_pwm.sv
`timescale 1ns/1ps
// How it works
// - duty times period gives compare threshold
// - threshold compared with free-running period counter
// - four rails, stages mapped per rail
// - converter trigger from rail's first engine
// - rails offset by 3/13 fastest period
// - stages spaced by period over stage count
// - sync rising edge restarts selected rail counters
// - sync word upper byte selects sync output
// - sync word lower byte masks following rails
// - once synced, rail offsets dropped until reset
// - below low limit, shed configured stages
// - light load loads light coefficient bank
// - above high limit, restore stages and bank
// - calibrate eight readings with gain, offset
// - over/under current limit declares fault
// - one rail sampled every 200 us
// - smoothing filter about 3.5 intervals
// - reading returns sum of rail stages
// - shared converter; four primaries fast-compare
// - zero quick trip level disables comparator
// - all rails from one common clock
// - bank one regulate, two light, zero ramp
module multirail_pwm
  import pwm_engine_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  // Clock, reset, enable
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_SYS_RST,
  input  wire logic              I_CE,
  input  wire logic              I_SOFT_RESET,
  // Configuration
  input  wire logic [NUM_RAILS*CNT_W-1:0]  I_RAIL_PERIOD,
  input  wire logic [NUM_STAGES*2-1:0]     I_RAIL_STAGE_MAPPING_CMD,
  input  wire logic [15:0]                 I_SYNC_CFG,
  input  wire logic [NUM_RAILS-1:0]        I_SHED_EN,
  input  wire logic [NUM_RAILS-1:0]        I_LIGHT_COMP_EN,
  input  wire logic [NUM_RAILS*3-1:0]      I_SHED_COUNT,
  input  wire logic [NUM_RAILS-1:0]        I_RAMPING,
  input  wire rail_limits_t [NUM_RAILS-1:0] I_LIMITS,
  input  wire stage_cal_t [NUM_STAGES-1:0]  I_CAL,
  input  wire logic [4*6-1:0]              I_QUICK_TRIP_LEVEL,
  // Compensator duty words
  input  wire logic [NUM_RAILS*DUTY_W-1:0] I_DUTY,
  // Sync and current sense
  input  wire logic              I_SYNC_IN,
  input  wire logic [CUR_W-1:0]  I_ADC_DATA,
  input  wire logic              I_ADC_VALID,
  input  wire logic [3:0]        I_QUICK_TRIP_CMP,
  input  wire logic [1:0]        I_READ_RAIL,
  // Gate drive and status
  output logic [NUM_STAGES-1:0]  O_GATE,
  output logic                   O_SYNC_OUT,
  output logic [NUM_RAILS-1:0]   O_ERROR_CONVERTER_TRIG,
  output logic [NUM_RAILS-1:0]   O_SENSE_EN,
  output logic [2:0]             O_ADC_CH,
  output logic [NUM_RAILS-1:0]   O_FAULT,
  output logic [NUM_RAILS*2-1:0] O_COEF_BANK,
  output logic [NUM_RAILS-1:0]   O_LIGHT_LOAD,
  output logic [15:0]            O_READ_CURRENT,
  output logic [3:0]             O_QUICK_TRIP_EN
);
  logic [1:0]        stage_rail   [NUM_STAGES];
  logic [2:0]        stage_idx    [NUM_STAGES];
  logic [3:0]        rail_nstg    [NUM_RAILS];
  logic [2:0]        rail_first   [NUM_RAILS];
  logic [CNT_W-1:0]  stage_start  [NUM_STAGES];
  logic [NUM_STAGES-1:0] pulse, wrap, stage_en;
  logic [15:0]       stage_avg    [NUM_STAGES];
  logic [CNT_W-1:0]  fastest;
  logic              sync_d_r, sync_rise;
  logic              synced_r;
  logic [NUM_RAILS-1:0] light_r;
  logic [NUM_RAILS-1:0] fault_r;
  logic [31:0]       tick_r;
  logic [1:0]        rail_ptr_r;
  logic [2:0]        ch_r;
  logic [NUM_STAGES-1:0] load;
  logic [17:0]       rail_sum [NUM_RAILS];
  logic [CNT_W+1:0]  spread;
  logic              restart_all;

  // Stage to rail map; each stage's order within its rail
  always_comb begin
    for (int r = 0; r < NUM_RAILS; r++) begin
      rail_nstg[r]  = 4'h0;
      rail_first[r] = 3'h0;
    end
    for (int s = NUM_STAGES - 1; s >= 0; s--) begin
      stage_rail[s] = I_RAIL_STAGE_MAPPING_CMD[2*s +: 2];
      rail_first[stage_rail[s]] = 3'(s);
    end
    for (int s = 0; s < NUM_STAGES; s++) begin
      stage_idx[s] = rail_nstg[stage_rail[s]][2:0];
      rail_nstg[stage_rail[s]] = rail_nstg[stage_rail[s]] + 4'h1;
    end
  end

  // Period of the fastest rail in use
  always_comb begin
    fastest = 16'hFFFF;
    for (int r = 0; r < NUM_RAILS; r++) begin
      if (rail_nstg[r] != 4'h0 &&
          I_RAIL_PERIOD[r*CNT_W +: CNT_W] < fastest) begin
        fastest = I_RAIL_PERIOD[r*CNT_W +: CNT_W];
      end
    end
    spread = (CNT_W+2)'((32'(fastest) * SPREAD_NUM) / SPREAD_DEN);
  end

  assign sync_rise   = I_SYNC_IN && !sync_d_r;
  assign restart_all = I_SOFT_RESET;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      sync_d_r <= 1'b0;
    end else if (I_CE) begin
      sync_d_r <= I_SYNC_IN;
    end
  end

  // Sync alignment latches until soft reset
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      synced_r <= 1'b0;
    end else if (I_CE) begin
      // A sync edge in the same cycle as soft reset wins
      if (sync_rise && |I_SYNC_CFG[NUM_RAILS-1:0]) begin
        synced_r <= 1'b1;
      end else if (I_SOFT_RESET) begin
        synced_r <= 1'b0;
      end
    end
  end

  // One pulse engine per stage, one common clock
  genvar g;
  generate
    for (g = 0; g < NUM_STAGES; g++) begin : g_stage
      logic [CNT_W-1:0] per;
      logic [CNT_W+3:0] off;
      logic             rst_stage;
      assign per = I_RAIL_PERIOD[stage_rail[g]*CNT_W +: CNT_W];
      // Rail offset plus stage spread
      assign off = (synced_r ? (CNT_W+4)'(0) :
                   (CNT_W+4)'(spread * stage_rail[g])) +
                   (CNT_W+4)'((32'(per) * stage_idx[g]) /
                   (rail_nstg[stage_rail[g]] == 4'h0 ? 32'd1 :
                    32'(rail_nstg[stage_rail[g]])));
      assign stage_start[g] = CNT_W'(off % (CNT_W+4)'(per == '0 ? 1 : per));
      // Restart on selected sync edge
      assign rst_stage = restart_all ||
        (sync_rise && I_SYNC_CFG[stage_rail[g]]);
      stage_pulse_engine #(.W(CNT_W)) u_eng (
        .clk       (I_CLK_SYS),
        .rst       (I_SYS_RST),
        .ce        (I_CE),
        .period    (per),
        .start_val ((per - stage_start[g]) % (per == '0 ? 16'h0001 : per)),
        .duty      (I_DUTY[stage_rail[g]*DUTY_W +: DUTY_W]),
        .restart   (rst_stage),
        .enable    (stage_en[g]),
        .pulse     (pulse[g]),
        .wrap      (wrap[g])
      );
      // Calibrated, smoothed stage current
      current_monitor u_mon (
        .clk  (I_CLK_SYS),
        .rst  (I_SYS_RST),
        .ce   (I_CE),
        .load (load[g]),
        .raw  (I_ADC_DATA),
        .cal  (I_CAL[g]),
        .avg  (stage_avg[g])
      );
      // Stages past the kept count, other than the rail's first, are shed at light load
      assign stage_en[g] = !(light_r[stage_rail[g]] &&
        (4'(stage_idx[g]) >= rail_nstg[stage_rail[g]] -
         4'(I_SHED_COUNT[stage_rail[g]*3 +: 3])) && stage_idx[g] != 3'h0);
    end
  endgenerate

  // Sample rail every interval, its stages in turn
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      tick_r     <= '0;
      rail_ptr_r <= '0;
    end else if (I_CE) begin
      if (tick_r >= 32'(SAMPLE_CYCLES - 1)) begin
        tick_r     <= '0;
        rail_ptr_r <= rail_ptr_r + 2'd1;
      end else begin
        tick_r <= tick_r + 32'd1;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      ch_r <= '0;
    end else if (I_CE && I_ADC_VALID) begin
      ch_r <= ch_r + 3'd1;
    end
  end

  always_comb begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      load[s] = I_ADC_VALID && (ch_r == 3'(s)) &&
                (stage_rail[s] == rail_ptr_r);
    end
  end

  // Rail sums of stage averages
  always_comb begin
    for (int r = 0; r < NUM_RAILS; r++) begin
      rail_sum[r] = '0;
    end
    for (int s = 0; s < NUM_STAGES; s++) begin
      rail_sum[stage_rail[s]] = rail_sum[stage_rail[s]] +
                                18'(stage_avg[s]);
    end
  end

  // Light-load hysteresis per rail
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      light_r <= '0;
    end else if (I_CE) begin
      for (int r = 0; r < NUM_RAILS; r++) begin
        if (!I_SHED_EN[r]) begin
          light_r[r] <= 1'b0;
        end else if (rail_sum[r] < 18'(I_LIMITS[r].light_lo)) begin
          light_r[r] <= 1'b1;
        end else if (rail_sum[r] > 18'(I_LIMITS[r].light_hi)) begin
          light_r[r] <= 1'b0;
        end
      end
    end
  end

  // Current fault, sticky until reset
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      fault_r <= '0;
    end else if (I_CE) begin
      for (int r = 0; r < NUM_RAILS; r++) begin
        if (rail_sum[r] > 18'(I_LIMITS[r].oc_limit) ||
            rail_sum[r] < 18'(I_LIMITS[r].uc_limit) ||
            (r < 4 && I_QUICK_TRIP_CMP[r] &&
             I_QUICK_TRIP_LEVEL[r*6 +: 6] != 6'h00)) begin
          fault_r[r] <= 1'b1;
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_GATE                 <= '0;
      O_SYNC_OUT             <= 1'b0;
      O_ERROR_CONVERTER_TRIG <= '0;
      O_SENSE_EN             <= '0;
      O_ADC_CH               <= '0;
      O_FAULT                <= '0;
      O_COEF_BANK            <= '0;
      O_LIGHT_LOAD           <= '0;
      O_READ_CURRENT         <= '0;
      O_QUICK_TRIP_EN        <= '0;
    end else if (I_CE) begin
      for (int s = 0; s < NUM_STAGES; s++) begin
        // Recovery action: faulted rail outputs held low
        O_GATE[s] <= pulse[s] && !fault_r[stage_rail[s]];
      end
      // Sync output from selected engine
      O_SYNC_OUT <= (I_SYNC_CFG[15:SYNC_OUT_LSB] < 8'(SYNC_OUT_OFF)) &&
        wrap[rail_first[I_SYNC_CFG[SYNC_OUT_LSB +: 2]]] &&
        rail_nstg[I_SYNC_CFG[SYNC_OUT_LSB +: 2]] != 4'h0;
      for (int r = 0; r < NUM_RAILS; r++) begin
        // Trigger from rail's first engine; unused sense off
        O_ERROR_CONVERTER_TRIG[r] <= rail_nstg[r] != 4'h0 &&
                                     wrap[rail_first[r]];
        O_SENSE_EN[r] <= rail_nstg[r] != 4'h0;
        // Bank choice
        O_COEF_BANK[r*2 +: 2] <= I_RAMPING[r] ? BANK_RAMP :
          (light_r[r] && I_LIGHT_COMP_EN[r]) ? BANK_LIGHT : BANK_REGULAR;
        // Fast comparator enable
        if (r < 4) begin
          O_QUICK_TRIP_EN[r] <= I_QUICK_TRIP_LEVEL[r*6 +: 6] != 6'h00;
        end
      end
      O_ADC_CH       <= ch_r;
      O_FAULT        <= fault_r;
      O_LIGHT_LOAD   <= light_r;
      O_READ_CURRENT <= rail_sum[I_READ_RAIL][15:0];
    end
  end
endmodule

// File: multirail_pwm_checker.sv
`timescale 1ns/1ps
module multirail_pwm_checker
  import pwm_engine_pkg::*;
(
  // Clock and reset
  input wire logic                  I_CLK_SYS,
  input wire logic                  I_SYS_RST,
  input wire logic                  I_CE,
  // Configuration
  input wire logic [NUM_STAGES*2-1:0] I_RAIL_STAGE_MAPPING_CMD,
  input wire logic [15:0]           I_SYNC_CFG,
  input wire logic [NUM_RAILS-1:0]  I_RAMPING,
  input wire logic [4*6-1:0]        I_QUICK_TRIP_LEVEL,
  // Outputs watched
  input wire logic                  O_SYNC_OUT,
  input wire logic [NUM_RAILS-1:0]  O_ERROR_CONVERTER_TRIG,
  input wire logic [NUM_RAILS-1:0]  O_SENSE_EN,
  input wire logic [NUM_RAILS-1:0]  O_FAULT,
  input wire logic [NUM_RAILS*2-1:0] O_COEF_BANK,
  input wire logic [3:0]            O_QUICK_TRIP_EN
);
  logic [NUM_RAILS-1:0] used;
  logic [NUM_RAILS-1:0] trip_nz;
  logic [NUM_RAILS-1:0] bank_nz;
  logic [NUM_RAILS-1:0] bank_bad;
  logic                 live_r;
  always_comb begin
    used = '0;
    for (int i = 0; i < NUM_STAGES; i++)
      used[I_RAIL_STAGE_MAPPING_CMD[2*i+:2]] = 1'b1;
    for (int r = 0; r < NUM_RAILS; r++) begin
      trip_nz[r] = |I_QUICK_TRIP_LEVEL[6*r+:6];
      bank_nz[r] = |O_COEF_BANK[2*r+:2];
      bank_bad[r] = &O_COEF_BANK[2*r+:2];
    end
  end
  // Previous edge was a running, non-reset edge
  always_ff @(posedge I_CLK_SYS) live_r <= I_CE && !I_SYS_RST;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  sync_out_off_a: assert property (live_r && $past(I_SYNC_CFG[15:8]) > 8'h03
    && $past(I_SYNC_CFG[15:8], 2) > 8'h03 |-> !O_SYNC_OUT)
    else $error("sync output pulsed while disabled");
  sync_pulse_one_a: assert property (I_CE && O_SYNC_OUT |=> !O_SYNC_OUT)
    else $error("sync output longer than one cycle");
  trig_pulse_one_a: assert property (I_CE && |O_ERROR_CONVERTER_TRIG |=>
    (O_ERROR_CONVERTER_TRIG & $past(O_ERROR_CONVERTER_TRIG)) == '0)
    else $error("converter trigger longer than one cycle");
  fault_sticky_a: assert property (O_FAULT != '0 |=>
    (O_FAULT & $past(O_FAULT)) == $past(O_FAULT))
    else $error("fault flag cleared without reset");
  trip_en_map_a: assert property (live_r |-> O_QUICK_TRIP_EN == $past(trip_nz))
    else $error("quick trip enable mismatch");
  sense_en_map_a: assert property (live_r |-> O_SENSE_EN == $past(used))
    else $error("sense enable does not follow mapping");
  ramp_bank_zero_a: assert property (live_r |-> (bank_nz & $past(I_RAMPING)) == '0)
    else $error("ramping rail not on bank zero");
  bank_legal_a: assert property (bank_bad == '0)
    else $error("illegal coefficient bank");
  cover property (O_SYNC_OUT);
  cover property (O_FAULT != '0);
  cover property ($rose(|O_ERROR_CONVERTER_TRIG));
endmodule

bind multirail_pwm multirail_pwm_checker i_multirail_pwm_checker (
  .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE),
  .I_RAIL_STAGE_MAPPING_CMD(I_RAIL_STAGE_MAPPING_CMD),
  .I_SYNC_CFG(I_SYNC_CFG), .I_RAMPING(I_RAMPING),
  .I_QUICK_TRIP_LEVEL(I_QUICK_TRIP_LEVEL), .O_SYNC_OUT(O_SYNC_OUT),
  .O_ERROR_CONVERTER_TRIG(O_ERROR_CONVERTER_TRIG), .O_SENSE_EN(O_SENSE_EN),
  .O_FAULT(O_FAULT), .O_COEF_BANK(O_COEF_BANK),
  .O_QUICK_TRIP_EN(O_QUICK_TRIP_EN));

// File: power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model
  import pwm_engine_pkg::*;
(
  // Clock and channel select
  input  wire logic                        i_clk,
  input  wire logic [2:0]                  i_ch,
  input  wire logic [NUM_STAGES*CUR_W-1:0] i_cur,
  // Converter result
  output logic [CUR_W-1:0]                 o_data,
  output logic                             o_valid
);
  int unsigned tick;
  initial begin
    tick = 0;
    o_data = '0;
    o_valid = 1'b0;
  end
  // One conversion every four cycles; data churns in between
  always @(negedge i_clk) begin
    tick <= tick + 1;
    o_valid <= (tick % 4 == 3);
    o_data <= (tick % 4 == 3) ? i_cur[CUR_W*i_ch+:CUR_W] : ~o_data;
  end
endmodule

// File: multirail_pwm_phase_current_engine_tb_top.sv
`timescale 1ns/1ps
module multirail_pwm_phase_current_engine_tb_top
  import pwm_engine_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_RAILS*CNT_W-1:0] period;
  logic [NUM_RAILS*DUTY_W-1:0] duty;
  logic [15:0] map, sync_cfg, rcur;
  logic [3:0] shed_en, lc_en, ramp, fault, llite, trip_en;
  logic [11:0] shed_cnt;
  logic [23:0] qt;
  logic [1:0] rd;
  rail_limits_t [NUM_RAILS-1:0] lim;
  stage_cal_t [NUM_STAGES-1:0] cal;
  logic [NUM_STAGES*CUR_W-1:0] cur;
  logic [CUR_W-1:0] adc;
  logic adc_v, sync_o;
  logic sync_i = 1'b0;
  logic [7:0] gate, bank, prev;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'h231fd9e4;
  int w[4], hi[8], rise[8], syncs, p[5];
  always #5 clk = ~clk;

  multirail_pwm #(.SAMPLE_CYCLES(20)) i_multirail_pwm (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_SOFT_RESET(1'b0),
    .I_RAIL_PERIOD(period), .I_RAIL_STAGE_MAPPING_CMD(map),
    .I_SYNC_CFG(sync_cfg), .I_SHED_EN(shed_en), .I_LIGHT_COMP_EN(lc_en),
    .I_SHED_COUNT(shed_cnt), .I_RAMPING(ramp), .I_LIMITS(lim), .I_CAL(cal),
    .I_QUICK_TRIP_LEVEL(qt), .I_DUTY(duty), .I_SYNC_IN(sync_i),
    .I_ADC_DATA(adc), .I_ADC_VALID(adc_v), .I_QUICK_TRIP_CMP(4'h0),
    .I_READ_RAIL(rd), .O_GATE(gate), .O_SYNC_OUT(sync_o),
    .O_ERROR_CONVERTER_TRIG(), .O_SENSE_EN(), .O_ADC_CH(),
    .O_FAULT(fault), .O_COEF_BANK(bank), .O_LIGHT_LOAD(llite),
    .O_READ_CURRENT(rcur), .O_QUICK_TRIP_EN(trip_en));
  power_stage_model i_power_stage_model (.i_clk(clk),
    .i_ch(i_multirail_pwm.O_ADC_CH), .i_cur(cur), .o_data(adc),
    .o_valid(adc_v));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Filtered currents settle within a few counts of the input
  task automatic check_cur(input logic [15:0] got, input int exp);
    comparisons++;
    if ($isunknown(got) || int'(got) > exp + 8 || int'(got) + 8 < exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic measure(input int n);
    hi = '{default:0};
    rise = '{default:-1};
    syncs = 0;
    prev = gate;
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      for (int s = 0; s < 8; s++) begin
        hi[s] += gate[s];
        if (gate[s] && !prev[s] && rise[s] < 0) rise[s] = k;
      end
      syncs += sync_o;
      prev = gate;
    end
  endtask

  initial begin
    #400000;
    failures++;
    final_report;
  end

  initial begin
    p = '{100, 120, 150, 200, 0};
    period = {16'h00C8, 16'h0096, 16'h0078, 16'h0064};
    map = 16'hFA50;
    sync_cfg = 16'h0000;
    rd = 2'h0;
    shed_en = 4'h4;
    lc_en = 4'h4;
    shed_cnt = 12'h040;
    ramp = 4'h8;
    for (int r = 0; r < 4; r++) begin
      duty[16*r+:16] = 16'($random(seed));
      lim[r] = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
      qt[6*r+:6] = (r == 1) ? 6'h00 : 6'($random(seed)) | 6'h01;
    end
    duty[15:0] = {2'h1, 14'($random(seed))};
    lim[2].light_lo = 16'h03E8;
    lim[2].light_hi = 16'h07D0;
    lim[3].oc_limit = 16'h0064;
    for (int s = 0; s < 8; s++) begin
      cal[s] = '{12'h100, 12'h000};
      cur[12*s+:12] = (s < 4) ? 12'($random(seed)) & 12'h3FF :
                      (s < 6) ? 12'h032 : 12'h1F4;
    end
    for (int r = 0; r < 4; r++)
      w[r] = (p[r] * int'(duty[16*r+:16])) >> 16;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (5000) @(negedge clk);
    for (int sel = 0; sel < 5; sel++) begin
      sync_cfg = {8'(sel), 8'h00};
      repeat (4) @(negedge clk);
      measure(1200);
      check(16'(syncs), 16'((sel < 4) ? 1200 / p[sel] : 0));
      check(16'(hi[0]), 16'(12 * w[0]));
      check(16'(hi[2]), 16'(10 * w[1]));
      check(16'(hi[4]), 16'(8 * w[2]));
      check(16'(hi[5]), 16'h0000);
      check(16'((rise[1] - rise[0] + 100) % 100), 16'h0032);
    end
    // Sync edge restarts rail 0, whose wrap then drives sync out
    sync_cfg = 16'h0001;
    repeat (3) @(negedge clk);
    sync_i = 1'b1;
    @(negedge clk);
    sync_i = 1'b0;
    @(negedge clk);
    check(16'(sync_o), 16'h0001);
    for (int r = 0; r < 4; r++) begin
      rd = 2'(r);
      repeat (3) @(negedge clk);
      check_cur(rcur, int'(cur[24*r+:12]) + int'(cur[24*r+12+:12]));
    end
    check(16'(fault), 16'h0008);
    check(16'(llite), 16'h0004);
    check(16'(bank), {8'h00, 2'h0, BANK_LIGHT, BANK_REGULAR, BANK_REGULAR});
    check(16'(trip_en), 16'h000D);
    cur[48+:24] = {12'h5DC, 12'h5DC};
    repeat (5000) @(negedge clk);
    measure(1200);
    check(16'(hi[5]), 16'(8 * w[2]));
    check(16'(llite), 16'h0000);
    check(16'(bank[5:4]), 16'(BANK_REGULAR));
    final_report;
  end
endmodule
